// file: pkg/panel_power_pkg.sv
/*
 * Package for the panel power control register bank: register indices,
 * field positions, reset values and the carrier structs.
 * Assumes an 8-bit index-addressed CPU port on the same clock as the bank.
 */
`default_nettype none
package panel_power_pkg;

    // register indices, as selected through the index register
    localparam logic [7:0] IDX_POWER_CHIP_CONTROL  = 8'h19;
    localparam logic [7:0] IDX_BOOST_RATIO_SELECT  = 8'h1a;
    localparam logic [7:0] IDX_COMMON_CENTER_DAC   = 8'h1d;
    localparam logic [7:0] IDX_AMP_BIAS_CONTROL    = 8'h1e;
    localparam logic [7:0] IDX_REF_AMP_MODE_BIAS   = 8'h1f;
    localparam logic [7:0] IDX_GAMMA_POS_BLACK     = 8'h24;
    localparam logic [7:0] IDX_GAMMA_NEG_WHITE     = 8'h25;
    localparam logic [7:0] IDX_GAMMA_POS_WHITE     = 8'h26;
    localparam logic [7:0] IDX_GAMMA_NEG_LEVEL     = 8'h27;
    localparam logic [7:0] IDX_PRECHARGE_THRESHOLD = 8'h28;
    localparam logic [7:0] IDX_GAMMA_INPUT_DISC    = 8'h2a;
    localparam logic [7:0] IDX_PRECHARGE_LENGTH    = 8'h2e;
    localparam logic [7:0] IDX_OUTPUT_PORT         = 8'h31;
    localparam logic [7:0] IDX_INPUT_PORT          = 8'h32;
    localparam logic [7:0] IDX_INTERFACE_VOLTAGE   = 8'h72;
    localparam logic [7:0] IDX_LOGIC_VOLTAGE       = 8'h73;

    // power_chip_control fields
    localparam int BIT_SUPPLY_SRC   = 6;
    localparam int BIT_HIGH_BOOST   = 5;
    localparam int BIT_SECOND_RAIL  = 4;
    localparam int BIT_PRECHG_LEVEL = 3;
    localparam int BIT_GATE_REG     = 2;
    localparam int BIT_SUPPLY_REG   = 1;
    localparam int BIT_CONVERTER    = 0;
    // boost_ratio_select fields
    localparam int BIT_BOOST_HI     = 1;
    localparam int BIT_BOOST_LO     = 0;
    // amplifier_bias_control / reference_amp_mode_bias / gamma_input_disconnect fields
    localparam int BIT_CAP_SWITCH   = 7;
    localparam int BIT_CENTER_STOP  = 3;
    localparam int BIT_WHITE_HP     = 7;
    localparam int BIT_BLACK_HP     = 3;
    localparam int FLD_HI_LSB       = 4;
    localparam int FLD_LO_LSB       = 0;
    localparam int BIT_GAMMA_SWITCH = 0;

    localparam logic [7:0] MASK_POWER_CTRL = 8'h7f;
    localparam logic [7:0] MASK_LOW2       = 8'h03;
    localparam logic [7:0] MASK_LOW1       = 8'h01;
    localparam logic [7:0] RESET_ZERO      = 8'h00;
    localparam logic [7:0] RESET_VOLTAGE   = 8'h03;
    localparam logic [7:0] THR_NIBBLE      = 8'h0f;

    // cpu access request from the interface decoder
    typedef struct packed {
        logic       sel_index;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } cpu_req_t;

    // whole register state of the bank
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] power_chip_control;
        logic [7:0] boost_ratio_select;
        logic [7:0] common_center_dac_code;
        logic [7:0] amplifier_bias_control;
        logic [7:0] reference_amp_mode_bias;
        logic [7:0] gamma_pos_black_level;
        logic [7:0] gamma_neg_white_level;
        logic [7:0] gamma_pos_white_level;
        logic [7:0] gamma_neg_level;
        logic [7:0] precharge_direction_threshold;
        logic [7:0] gamma_input_disconnect;
        logic [7:0] precharge_length;
        logic [7:0] output_port;
        logic [7:0] interface_voltage_select;
        logic [7:0] logic_voltage_select;
        logic [7:0] rdata;
        logic [3:0] in_sync1;
        logic [3:0] in_sync2;
    } bank_state_t;

    // pins toward the power chip and gate driver
    typedef struct packed {
        logic       common_supply_source_sel;
        logic       high_boost_level_sel;
        logic       second_rail_ratio_sel;
        logic       precharge_level_sel;
        logic       gate_regulator_enable;
        logic       supply_regulator_enable;
        logic       converter_enable;
        logic       boost_ratio_hi;
        logic       boost_ratio_lo;
    } power_pins_t;

    // codes toward the analog blocks
    typedef struct packed {
        logic [7:0] common_center_code;
        logic       amp_capacity_switch;
        logic [2:0] center_amp_bias;
        logic       center_amp_stop;
        logic [2:0] source_output_bias;
        logic       white_amp_high_power;
        logic [2:0] white_amp_bias;
        logic       black_amp_high_power;
        logic [2:0] black_amp_bias;
        logic [7:0] pos_black_gamma_code;
        logic [7:0] neg_white_gamma_code;
        logic [7:0] pos_white_gamma_code;
        logic [7:0] neg_low_gamma_code;
        logic       gamma_input_switch;
        logic [7:0] precharge_clock_count;
        logic [1:0] interface_voltage_code;
        logic [1:0] logic_voltage_code;
    } analog_codes_t;

endpackage
`default_nettype wire

// file: core/panel_power_control_regs.sv
/*
 * Panel power control register bank: index-addressed 8-bit registers that
 * drive power-chip and gate-driver pins, analog codes, a general output port
 * and pre-charge direction compare against display RAM pixel data.
 * Assumes the cpu port decoder issues one-cycle wr/rd strobes on ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module panel_power_control_regs
    import panel_power_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    input  wire cpu_req_t      cpu_req,
    output logic [7:0]         cpu_rdata,
    input  wire logic [3:0]    general_input_pins,
    input  wire logic [17:0]   pixel_data,
    input  wire logic          drive_polarity_neg,
    output logic [7:0]         general_output_pins,
    output power_pins_t        power_pins,
    output analog_codes_t      analog_codes,
    output logic [2:0]         precharge_dir_up
);

    bank_state_t s_q;
    bank_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // threshold compare of one colour's upper nibble

    function automatic logic above_thr(input logic [5:0] comp,
                                       input logic [3:0] thr);
        above_thr = comp[5:2] >= thr;
    endfunction

    function automatic logic [2:0] field3(input logic [7:0] r, input int lsb);
        field3 = r[lsb +: 3];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        s_d.in_sync1 = general_input_pins;
        s_d.in_sync2 = s_q.in_sync1;
        if (cpu_req.wr && cpu_req.sel_index) begin
            s_d.index = cpu_req.wdata;
        end else if (cpu_req.wr) begin
            unique case (s_q.index)
                IDX_POWER_CHIP_CONTROL:
                    s_d.power_chip_control = cpu_req.wdata & MASK_POWER_CTRL;
                IDX_BOOST_RATIO_SELECT:
                    s_d.boost_ratio_select = cpu_req.wdata & MASK_LOW2;
                IDX_COMMON_CENTER_DAC:   s_d.common_center_dac_code = cpu_req.wdata;
                IDX_AMP_BIAS_CONTROL:    s_d.amplifier_bias_control = cpu_req.wdata;
                IDX_REF_AMP_MODE_BIAS:   s_d.reference_amp_mode_bias = cpu_req.wdata;
                IDX_GAMMA_POS_BLACK:     s_d.gamma_pos_black_level = cpu_req.wdata;
                IDX_GAMMA_NEG_WHITE:     s_d.gamma_neg_white_level = cpu_req.wdata;
                IDX_GAMMA_POS_WHITE:     s_d.gamma_pos_white_level = cpu_req.wdata;
                IDX_GAMMA_NEG_LEVEL:     s_d.gamma_neg_level = cpu_req.wdata;
                IDX_PRECHARGE_THRESHOLD:
                    s_d.precharge_direction_threshold = cpu_req.wdata;
                IDX_GAMMA_INPUT_DISC:
                    s_d.gamma_input_disconnect = cpu_req.wdata & MASK_LOW1;
                IDX_PRECHARGE_LENGTH:    s_d.precharge_length = cpu_req.wdata;
                IDX_OUTPUT_PORT:         s_d.output_port = cpu_req.wdata;
                IDX_INTERFACE_VOLTAGE:
                    s_d.interface_voltage_select = cpu_req.wdata & MASK_LOW2;
                IDX_LOGIC_VOLTAGE:
                    s_d.logic_voltage_select = cpu_req.wdata & MASK_LOW2;
                default: ;
            endcase
        end
        if (cpu_req.rd && cpu_req.sel_index) begin
            s_d.rdata = s_q.index;
        end else if (cpu_req.rd) begin
            unique case (s_q.index)
                IDX_POWER_CHIP_CONTROL:  s_d.rdata = s_q.power_chip_control;
                IDX_BOOST_RATIO_SELECT:  s_d.rdata = s_q.boost_ratio_select;
                IDX_COMMON_CENTER_DAC:   s_d.rdata = s_q.common_center_dac_code;
                IDX_AMP_BIAS_CONTROL:    s_d.rdata = s_q.amplifier_bias_control;
                IDX_REF_AMP_MODE_BIAS:   s_d.rdata = s_q.reference_amp_mode_bias;
                IDX_GAMMA_POS_BLACK:     s_d.rdata = s_q.gamma_pos_black_level;
                IDX_GAMMA_NEG_WHITE:     s_d.rdata = s_q.gamma_neg_white_level;
                IDX_GAMMA_POS_WHITE:     s_d.rdata = s_q.gamma_pos_white_level;
                IDX_GAMMA_NEG_LEVEL:     s_d.rdata = s_q.gamma_neg_level;
                IDX_PRECHARGE_THRESHOLD: s_d.rdata = s_q.precharge_direction_threshold;
                IDX_GAMMA_INPUT_DISC:    s_d.rdata = s_q.gamma_input_disconnect;
                IDX_PRECHARGE_LENGTH:    s_d.rdata = s_q.precharge_length;
                IDX_INPUT_PORT:
                    s_d.rdata = {4'h0, s_q.in_sync2};
                IDX_INTERFACE_VOLTAGE:   s_d.rdata = s_q.interface_voltage_select;
                IDX_LOGIC_VOLTAGE:       s_d.rdata = s_q.logic_voltage_select;
                default:                 s_d.rdata = RESET_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.interface_voltage_select <= RESET_VOLTAGE;
            s_q.logic_voltage_select <= RESET_VOLTAGE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins and codes

    always_comb begin
        cpu_rdata = s_q.rdata;
        general_output_pins = s_q.output_port;
        power_pins.common_supply_source_sel =
            s_q.power_chip_control[BIT_SUPPLY_SRC];
        power_pins.high_boost_level_sel = s_q.power_chip_control[BIT_HIGH_BOOST];
        power_pins.second_rail_ratio_sel = s_q.power_chip_control[BIT_SECOND_RAIL];
        power_pins.precharge_level_sel = s_q.power_chip_control[BIT_PRECHG_LEVEL];
        power_pins.gate_regulator_enable = s_q.power_chip_control[BIT_GATE_REG];
        power_pins.supply_regulator_enable = s_q.power_chip_control[BIT_SUPPLY_REG];
        power_pins.converter_enable = s_q.power_chip_control[BIT_CONVERTER];
        power_pins.boost_ratio_hi = s_q.boost_ratio_select[BIT_BOOST_HI];
        power_pins.boost_ratio_lo = s_q.boost_ratio_select[BIT_BOOST_LO];
        analog_codes.common_center_code = s_q.common_center_dac_code;
        analog_codes.amp_capacity_switch =
            s_q.amplifier_bias_control[BIT_CAP_SWITCH];
        analog_codes.center_amp_bias =
            field3(s_q.amplifier_bias_control, FLD_HI_LSB);
        analog_codes.center_amp_stop =
            s_q.amplifier_bias_control[BIT_CENTER_STOP];
        analog_codes.source_output_bias =
            field3(s_q.amplifier_bias_control, FLD_LO_LSB);
        analog_codes.white_amp_high_power =
            s_q.reference_amp_mode_bias[BIT_WHITE_HP];
        analog_codes.black_amp_high_power =
            s_q.reference_amp_mode_bias[BIT_BLACK_HP];
        analog_codes.white_amp_bias =
            field3(s_q.reference_amp_mode_bias, FLD_HI_LSB);
        analog_codes.black_amp_bias =
            field3(s_q.reference_amp_mode_bias, FLD_LO_LSB);
        analog_codes.pos_black_gamma_code = s_q.gamma_pos_black_level;
        analog_codes.neg_white_gamma_code = s_q.gamma_neg_white_level;
        analog_codes.pos_white_gamma_code = s_q.gamma_pos_white_level;
        analog_codes.neg_low_gamma_code = s_q.gamma_neg_level;
        analog_codes.gamma_input_switch =
            s_q.gamma_input_disconnect[BIT_GAMMA_SWITCH];
        analog_codes.precharge_clock_count = s_q.precharge_length;
        analog_codes.interface_voltage_code = s_q.interface_voltage_select[1:0];
        analog_codes.logic_voltage_code = s_q.logic_voltage_select[1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // pre-charge direction compare, red green blue

    logic [3:0] thr_sel;
    always_comb begin
        thr_sel = drive_polarity_neg ? 4'(s_q.precharge_direction_threshold & THR_NIBBLE)
                                     : 4'(s_q.precharge_direction_threshold >> FLD_HI_LSB);
        precharge_dir_up[2] = above_thr(pixel_data[17:12], thr_sel);
        precharge_dir_up[1] = above_thr(pixel_data[11:6], thr_sel);
        precharge_dir_up[0] = above_thr(pixel_data[5:0], thr_sel);
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    index_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.wr && cpu_req.sel_index |=> s_q.index == $past(cpu_req.wdata))
        else $error("index not taken");
    out_port_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.wr && !cpu_req.sel_index && s_q.index == IDX_OUTPUT_PORT
        |=> general_output_pins == $past(cpu_req.wdata))
        else $error("output port not driven");
    out_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(cpu_req.wr && !cpu_req.sel_index && s_q.index == IDX_OUTPUT_PORT)
        |=> $stable(general_output_pins))
        else $error("output port changed");
    converter_pin_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.wr && !cpu_req.sel_index && s_q.index == IDX_POWER_CHIP_CONTROL
        |=> power_pins.converter_enable == $past(cpu_req.wdata[0]))
        else $error("converter pin wrong");
    gate_reg_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.wr && !cpu_req.sel_index && s_q.index == IDX_POWER_CHIP_CONTROL
        |=> power_pins.gate_regulator_enable == $past(cpu_req.wdata[2]))
        else $error("gate regulator pin wrong");
    supply_reg_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.wr && !cpu_req.sel_index && s_q.index == IDX_POWER_CHIP_CONTROL
        |=> power_pins.supply_regulator_enable == $past(cpu_req.wdata[1]))
        else $error("supply regulator pin wrong");
    boost_pins_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.wr && !cpu_req.sel_index && s_q.index == IDX_BOOST_RATIO_SELECT
        |=> {power_pins.boost_ratio_hi, power_pins.boost_ratio_lo}
            == $past(cpu_req.wdata[1:0]))
        else $error("boost ratio pins wrong");
    input_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.rd && !cpu_req.sel_index && s_q.index == IDX_INPUT_PORT
        |=> cpu_rdata[7:4] == 4'h0 && cpu_rdata[3:0] == $past(general_input_pins, 3))
        else $error("input port read wrong");
    thr_cmp_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !drive_polarity_neg && pixel_data[17:14] >= s_q.precharge_direction_threshold[7:4]
        |-> precharge_dir_up[2])
        else $error("red compare wrong");
    center_bias_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.wr && !cpu_req.sel_index && s_q.index == IDX_AMP_BIAS_CONTROL
        |=> {analog_codes.center_amp_bias, analog_codes.center_amp_stop}
            == $past(cpu_req.wdata[6:3]))
        else $error("centre amp code wrong");
    rail_pins_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.wr && !cpu_req.sel_index && s_q.index == IDX_POWER_CHIP_CONTROL
        |=> {power_pins.common_supply_source_sel, power_pins.high_boost_level_sel,
             power_pins.second_rail_ratio_sel} == $past(cpu_req.wdata[6:4]))
        else $error("rail select pins wrong");

    write_cov_c: cover property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.wr && cpu_req.sel_index ##1 cpu_req.wr && !cpu_req.sel_index);
    read_cov_c: cover property (@(posedge ref_clk) disable iff (!rstn)
        cpu_req.rd && s_q.index == IDX_INPUT_PORT);
    power_on_c: cover property (@(posedge ref_clk) disable iff (!rstn)
        power_pins.converter_enable && power_pins.supply_regulator_enable);
    neg_dir_c: cover property (@(posedge ref_clk) disable iff (!rstn)
        drive_polarity_neg && precharge_dir_up[1]);

endmodule
`default_nettype wire

// file: dv/power_chip_model.sv
/*
 * Behavioural model of the external power chip and gate driver that sit on
 * the bank's dedicated control pins.
 * Assumes the pins are wired one to one, as the board must do.
 */
`timescale 1ns/1ns
`default_nettype none
module power_chip_model
    import panel_power_pkg::*;
(
    input  wire power_pins_t pins,
    output logic [3:0]       boost_mult,
    output logic [1:0]       rail_mult,
    output logic             high_level_same,
    output logic             gate_on,
    output logic             supply_on,
    output logic             conv_on
);
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        // four to seven times input
        boost_mult      = 4'h4 + {2'h0, pins.boost_ratio_hi, pins.boost_ratio_lo};
        rail_mult       = pins.second_rail_ratio_sel ? 2'h3 : 2'h2;
        high_level_same = pins.high_boost_level_sel;
        gate_on         = pins.gate_regulator_enable;
        supply_on       = pins.supply_regulator_enable;
        conv_on         = pins.converter_enable;
    end
endmodule
`default_nettype wire

// file: dv/panel_power_control_regs_tb_top.sv
/*
 * Self-checking bench for the panel power control register bank.
 * Assumes the index/data cpu port with one-cycle strobes on ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module panel_power_control_regs_tb_top
    import panel_power_pkg::*;
;
    logic          ref_clk = 1'b0;
    logic          rstn = 1'b0;
    cpu_req_t      cpu_req = '0;
    logic [7:0]    cpu_rdata;
    logic [3:0]    general_input_pins = 4'h0;
    logic [17:0]   pixel_data = 18'h0;
    logic          drive_polarity_neg = 1'b0;
    logic [7:0]    general_output_pins;
    power_pins_t   power_pins;
    analog_codes_t analog_codes;
    logic [2:0]    precharge_dir_up;
    logic [3:0]    boost_mult;
    logic [1:0]    rail_mult;
    logic          high_level_same;
    logic          gate_on;
    logic          supply_on;
    logic          conv_on;
    int            num_errors = 0;
    int            check_count = 0;
    logic [7:0]    v;
    logic [7:0]    e;
    logic [7:0]    idx_t [12] = '{IDX_POWER_CHIP_CONTROL, IDX_BOOST_RATIO_SELECT,
        IDX_COMMON_CENTER_DAC, IDX_AMP_BIAS_CONTROL, IDX_REF_AMP_MODE_BIAS,
        IDX_GAMMA_POS_BLACK, IDX_GAMMA_NEG_WHITE, IDX_GAMMA_POS_WHITE, IDX_GAMMA_NEG_LEVEL,
        IDX_PRECHARGE_THRESHOLD, IDX_GAMMA_INPUT_DISC, IDX_PRECHARGE_LENGTH};
    logic [7:0]    mask_t [12] = '{MASK_POWER_CTRL, MASK_LOW2, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, MASK_LOW1, 8'hff};

    always #5 ref_clk = ~ref_clk;

    panel_power_control_regs u_dut (
        .ref_clk            (ref_clk),
        .rstn               (rstn),
        .cpu_req            (cpu_req),
        .cpu_rdata          (cpu_rdata),
        .general_input_pins (general_input_pins),
        .pixel_data         (pixel_data),
        .drive_polarity_neg (drive_polarity_neg),
        .general_output_pins(general_output_pins),
        .power_pins         (power_pins),
        .analog_codes       (analog_codes),
        .precharge_dir_up   (precharge_dir_up)
    );

    power_chip_model u_model (
        .pins           (power_pins),
        .boost_mult     (boost_mult),
        .rail_mult      (rail_mult),
        .high_level_same(high_level_same),
        .gate_on        (gate_on),
        .supply_on      (supply_on),
        .conv_on        (conv_on)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one strobe, held for one cycle
    task automatic acc(input logic s, input logic w, input logic r, input logic [7:0] d);
        @(posedge ref_clk);
        cpu_req <= '{sel_index: s, wr: w, rd: r, wdata: d};
        @(posedge ref_clk);
        cpu_req.wr <= 1'b0;
        cpu_req.rd <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b1, 1'b1, 1'b0, idx);
        acc(1'b0, 1'b1, 1'b0, d);
        @(posedge ref_clk);
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
        acc(1'b1, 1'b1, 1'b0, idx);
        acc(1'b0, 1'b0, 1'b1, 8'h00);
        @(posedge ref_clk);
        #1;
        d = cpu_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        // power-on command reset, decoded outside this bank, ignored here
        wr_reg(8'h03, 8'h01);
        // reset values
        for (int i = 0; i < 12; i++) begin
            rd_reg(idx_t[i], v);
            chk("reset value", 32'(v), 32'(RESET_ZERO));
        end
        rd_reg(IDX_INTERFACE_VOLTAGE, v);
        chk("interface voltage reset", 32'(v), 32'(RESET_VOLTAGE));
        // power pin walk, one bit at a time
        for (int i = 0; i < 7; i++) begin
            e = 8'h01 << i;
            wr_reg(IDX_POWER_CHIP_CONTROL, e);
            chk("power pins", 32'(power_pins), 32'({e[6:0], 2'b00}));
            chk("partner view", 32'({gate_on, supply_on, conv_on, high_level_same, rail_mult}),
                32'({e[2], e[1], e[0], e[5], e[4] ? 2'h3 : 2'h2}));
        end
        for (int c = 0; c < 4; c++) begin
            wr_reg(IDX_BOOST_RATIO_SELECT, 8'(c));
            chk("boost pins", 32'({power_pins.boost_ratio_hi, power_pins.boost_ratio_lo}), 32'(c));
            chk("boost ratio", 32'(boost_mult), 32'(c + 4));
        end
        // write the twelve idx_t registers, read back masked, check codes
        for (int p = 0; p < 2; p++) begin
            e = p ? 8'h5a : 8'ha5;
            for (int i = 0; i < 12; i++) wr_reg(idx_t[i], e);
            for (int i = 0; i < 12; i++) begin
                rd_reg(idx_t[i], v);
                chk("readback", 32'(v), 32'(e & mask_t[i]));
            end
            chk("supply source", 32'(power_pins.common_supply_source_sel), 32'(e[6]));
            chk("centre dac", 32'(analog_codes.common_center_code), 32'(e));
            chk("gamma switch", 32'(analog_codes.gamma_input_switch), 32'(e[0]));
            chk("amp bias", 32'({analog_codes.amp_capacity_switch, analog_codes.center_amp_bias,
                analog_codes.center_amp_stop, analog_codes.source_output_bias}), 32'(e));
            chk("ref amp", 32'({analog_codes.white_amp_high_power, analog_codes.white_amp_bias,
                analog_codes.black_amp_high_power, analog_codes.black_amp_bias}), 32'(e));
            chk("gamma", {analog_codes.pos_black_gamma_code, analog_codes.neg_white_gamma_code,
                analog_codes.pos_white_gamma_code, analog_codes.neg_low_gamma_code}, {4{e}});
            chk("precharge length", 32'(analog_codes.precharge_clock_count), 32'(e));
        end
        // both voltage fields equal, at 11
        wr_reg(IDX_INTERFACE_VOLTAGE, 8'h03);
        wr_reg(IDX_LOGIC_VOLTAGE, 8'h03);
        chk("voltage codes", 32'({analog_codes.interface_voltage_code,
            analog_codes.logic_voltage_code}), 32'h0f);
        // pre-charge direction, threshold at boundary
        wr_reg(IDX_PRECHARGE_THRESHOLD, 8'h94);
        @(posedge ref_clk);
        pixel_data <= {6'b100100, 6'b100011, 6'b001111};
        @(posedge ref_clk);
        #1;
        chk("dir positive", 32'(precharge_dir_up), 32'h4);
        @(posedge ref_clk);
        drive_polarity_neg <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("dir negative", 32'(precharge_dir_up), 32'h6);
        // output port holds, reads as zero
        wr_reg(IDX_OUTPUT_PORT, 8'h3c);
        chk("output port", 32'(general_output_pins), 32'h3c);
        wr_reg(IDX_INPUT_PORT, 8'hff);
        chk("output port held", 32'(general_output_pins), 32'h3c);
        rd_reg(IDX_OUTPUT_PORT, v);
        chk("output port read", 32'(v), 32'h00);
        // input port levels
        @(posedge ref_clk);
        general_input_pins <= 4'ha;
        rd_reg(IDX_INPUT_PORT, v);
        chk("input port", 32'(v), 32'h0a);
        @(posedge ref_clk);
        general_input_pins <= 4'h5;
        rd_reg(IDX_INPUT_PORT, v);
        chk("input port", 32'(v), 32'h05);
        // unmapped index ignored
        wr_reg(8'h20, 8'hff);
        rd_reg(8'h20, v);
        chk("unmapped read", 32'(v), 32'h00);
        rd_reg(IDX_PRECHARGE_LENGTH, v);
        chk("neighbour kept", 32'(v), 32'h5a);
        final_report();
    end
endmodule
`default_nettype wire
